// [hw/flash_cmd_defines.svh]
// offsets, codes, field positions, reset values of the flash command unit
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// ------------------------------------------------------------
// register file offsets
// ------------------------------------------------------------
`define TRIM_BIT_DATA_ADDR      12'hff7
`define FLASH_COMMAND_PORT_ADDR 12'hff8
`define FLASH_STATE_PORT_ADDR   12'hff8

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define CMD_UNLOCK_FIRST        8'h73
`define CMD_UNLOCK_SECOND       8'h8c
`define CMD_PAGE_ERASE          8'h95
`define CMD_MASS_ERASE          8'h63
`define CMD_PROTECT_ACCESS      8'h5e

// ------------------------------------------------------------
// status field encoding, six low bits
// ------------------------------------------------------------
`define STAT_LOCKED             6'h00
`define STAT_FIRST              6'h01
`define STAT_UNLOCKED           6'h02
`define STAT_PAGE_ERASE         6'h08
`define STAT_MASS_ERASE         6'h0c

// ------------------------------------------------------------
// memory map
// ------------------------------------------------------------
`define INFO_AREA_LO            16'hfe00
`define INFO_AREA_HI            16'hffff
`define OPTION_ADDR0            16'h0000
`define OPTION_ADDR1            16'h0001

// ------------------------------------------------------------
// option byte 0 fields and reset values
// ------------------------------------------------------------
`define OPT_WATCHDOG_RESPONSE_SELECT_BIT         7
`define OPT_WATCHDOG_ALWAYS_ON_BIT          6
`define OPT_ERASED              8'hff
`define TRIM_RESET              8'h00
`define RDATA_RESET             8'h00

`endif

// [hw/flash_cmd_pkg.sv]
// types shared by the flash command unit
package flash_cmd_pkg;
    typedef enum logic [2:0] {
        ST_LOCKED   = 3'b000,
        ST_FIRST    = 3'b001,
        ST_UNLOCKED = 3'b011,
        ST_PAGE     = 3'b010,
        ST_MASS     = 3'b110
    } seq_state_t;

    typedef logic [7:0]  byte_t;
    typedef logic [11:0] rf_addr_t;
    typedef logic [15:0] mem_addr_t;
endpackage

// [hw/option_if.sv]
// option byte and watchdog signals between top and option store
`timescale 1ns/1ps
interface option_if;
    import flash_cmd_pkg::*;
    logic  wr;
    logic  idx;
    byte_t wdata;
    byte_t byte0;
    byte_t byte1;
    logic  wdt_instr;
    logic  wdt_timeout;
    logic  wdt_run;
    logic  wdt_irq;
    logic  wdt_sys_reset;

    modport owner (input wr, idx, wdata, wdt_instr, wdt_timeout,
                   output byte0, byte1, wdt_run, wdt_irq, wdt_sys_reset);
    modport user  (output wr, idx, wdata, wdt_instr, wdt_timeout,
                   input byte0, byte1, wdt_run, wdt_irq, wdt_sys_reset);
endinterface

// [hw/option_store.sv]
// option bytes kept across system reset, and watchdog start/response
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module option_store (
    // clocks and resets
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   por_n,
    // option and watchdog signals
    option_if.owner     opt
);
    import flash_cmd_pkg::*;

    logic run_q;
    logic run_d;
    logic irq_q;
    logic sysrst_q;
    logic ao_bit;
    logic res_bit;
    logic fire;

    assign ao_bit  = opt.byte0[`OPT_WATCHDOG_ALWAYS_ON_BIT];
    assign res_bit = opt.byte0[`OPT_WATCHDOG_RESPONSE_SELECT_BIT];
    // auto start when always-on is 0, else wait for the instruction
    assign run_d   = run_q | opt.wdt_instr | ~ao_bit; // [R16] [R17]
    assign fire    = run_q & opt.wdt_timeout;

    // only power-on sets these to the erased value FFH; system reset leaves them alone
    always_ff @(posedge clk or negedge por_n) begin // [R14]
        if (!por_n) begin
            opt.byte0 <= `OPT_ERASED;
            opt.byte1 <= `OPT_ERASED;
        end else if (opt.wr) begin
            if (opt.idx) begin
                opt.byte1 <= opt.wdata;
            end else begin
                opt.byte0 <= opt.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q    <= 1'b0;
            irq_q    <= 1'b0;
            sysrst_q <= 1'b0;
        end else begin
            run_q    <= run_d;
            irq_q    <= fire & ~res_bit; // [R15]
            sysrst_q <= fire & res_bit;  // [R15]
        end
    end

    assign opt.wdt_run       = run_q;
    assign opt.wdt_irq       = irq_q;
    assign opt.wdt_sys_reset = sysrst_q;
endmodule

// [hw/info_decode.sv]
// registered decode of the program and information memory map
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module info_decode #(
    parameter logic [15:0] DENY_LO = 16'hfe80,
    parameter logic [15:0] DENY_HI = 16'hfeff
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // memory address
    input  wire flash_cmd_pkg::mem_addr_t addr,
    // decode results
    output logic                         info_sel,
    output logic                         info_denied,
    output logic                         option_sel
);
    import flash_cmd_pkg::*;

    function automatic logic in_range(mem_addr_t a, mem_addr_t lo,
                                      mem_addr_t hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic info_w;
    logic deny_w;
    logic opt_w;

    assign info_w = in_range(addr, `INFO_AREA_LO, `INFO_AREA_HI); // [R12]
    assign deny_w = info_w & in_range(addr, DENY_LO, DENY_HI);    // [R12]
    assign opt_w  = in_range(addr, `OPTION_ADDR0, `OPTION_ADDR1); // [R13]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            info_sel    <= 1'b0;
            info_denied <= 1'b0;
            option_sel  <= 1'b0;
        end else begin
            info_sel    <= info_w;
            info_denied <= deny_w;
            option_sel  <= opt_w;
        end
    end
endmodule

// [hw/flash_cmd_unit.sv]
// flash command front end: unlock sequencer, status, trim, option bits
//
// What this block does
// R1: program and erase are refused until software unlocks the controller.
// R2: unlock needs command writes 73H then 8CH, back to back.
// R3: any invalid code or broken order relocks the controller.
// R4: page erase starts only on 95H as third command after unlock.
// R5: page erase touches only the page chosen by page select.
// R6: mass erase starts only on 63H as third command after unlock.
// R7: mass erase is accepted only from the on-chip debugger.
// R8: writing 5EH grants access to the sector protect register.
// R9: command (write) and status (read) share address FF8H.
// R10: status readable anytime, six low bits state, top two zero.
// R11: trim data register at FF7H, read/write, resets to zero.
// R12: information area decoded at FE00H-FFFFH, part of it inaccessible.
// R13: bytes 0000H and 0001H are option bits, not code.
// R14: option bits are never changed by system reset.
// R15: watchdog response bit 0 gives interrupt, 1 gives system reset.
// R16: always-on bit 0 starts the watchdog at power-up, undisableable.
// R17: always-on bit 1 waits for the watchdog instruction, then runs.
// R18: a finished erase relocks; unlock must be repeated.
// R19: status encodes locked, first code, unlocked, erase in progress.
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_unit (
    // clocks and resets
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     por_n,
    // register file access
    input  wire flash_cmd_pkg::rf_addr_t  rf_addr,
    input  wire logic                     rf_wr,
    input  wire logic                     rf_rd,
    input  wire flash_cmd_pkg::byte_t     rf_wdata,
    output flash_cmd_pkg::byte_t          rf_rdata,
    input  wire logic                     dbg_write,
    // flash array
    input  wire flash_cmd_pkg::byte_t     page_select,
    input  wire logic                     erase_done,
    output logic                          erase_start,
    output logic                          erase_mass,
    output flash_cmd_pkg::byte_t          erase_page,
    output logic                          prog_enable,
    output logic                          sector_protect_access,
    // memory bus
    input  wire flash_cmd_pkg::mem_addr_t mem_addr,
    input  wire logic                     mem_wr,
    input  wire flash_cmd_pkg::byte_t     mem_wdata,
    output logic                          info_sel,
    output logic                          info_denied,
    output logic                          option_sel,
    // option bits and watchdog
    input  wire logic                     wdt_instr,
    input  wire logic                     wdt_timeout,
    output flash_cmd_pkg::byte_t          option_byte0,
    output flash_cmd_pkg::byte_t          option_byte1,
    output logic                          wdt_run,
    output logic                          wdt_irq,
    output logic                          wdt_sys_reset
);
    import flash_cmd_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] stat_code(seq_state_t s); // [R19]
        case (s)
            ST_LOCKED:   stat_code = `STAT_LOCKED;
            ST_FIRST:    stat_code = `STAT_FIRST;
            ST_UNLOCKED: stat_code = `STAT_UNLOCKED;
            ST_PAGE:     stat_code = `STAT_PAGE_ERASE;
            ST_MASS:     stat_code = `STAT_MASS_ERASE;
            default:     stat_code = `STAT_LOCKED;
        endcase
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    seq_state_t state_q;
    seq_state_t state_d;
    byte_t      trim_q;
    byte_t      rdata_q;
    logic       protect_q;
    logic       start_q;
    logic       mass_q;
    byte_t      page_q;
    logic       cmd_wr;
    logic       trim_wr;
    logic       cmd_rd;
    logic       trim_rd;
    byte_t      rdata_d;
    logic       busy;
    logic       go_page;
    logic       go_mass;
    logic       opt_addr;

    assign cmd_wr  = rf_wr & (rf_addr == `FLASH_COMMAND_PORT_ADDR); // [R9]
    assign cmd_rd  = rf_rd & (rf_addr == `FLASH_STATE_PORT_ADDR);   // [R9]
    assign trim_wr = rf_wr & (rf_addr == `TRIM_BIT_DATA_ADDR);      // [R11]
    assign trim_rd = rf_rd & (rf_addr == `TRIM_BIT_DATA_ADDR);      // [R11]
    assign busy    = (state_q == ST_PAGE) | (state_q == ST_MASS);

    // reads of FF8H return only the status; the command port has no read path
    assign rdata_d = cmd_rd  ? {2'b00, stat_code(state_q)} :    // [R10]
                     trim_rd ? trim_q : `RDATA_RESET;

    assign go_page = (state_q == ST_UNLOCKED) & cmd_wr &
                     (rf_wdata == `CMD_PAGE_ERASE);              // [R4]
    // a mass erase from ordinary code is treated as an invalid code
    assign go_mass = (state_q == ST_UNLOCKED) & cmd_wr & dbg_write &
                     (rf_wdata == `CMD_MASS_ERASE);              // [R6] [R7]

    // ------------------------------------------------------------
    // unlock sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_LOCKED: begin
                if (cmd_wr && rf_wdata == `CMD_UNLOCK_FIRST) begin // [R2]
                    state_d = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (cmd_wr) begin
                    if (rf_wdata == `CMD_UNLOCK_SECOND) begin      // [R2]
                        state_d = ST_UNLOCKED;
                    end else begin
                        state_d = ST_LOCKED;                       // [R3]
                    end
                end
            end
            ST_UNLOCKED: begin
                if (go_page) begin
                    state_d = ST_PAGE;
                end else if (go_mass) begin
                    state_d = ST_MASS;
                end else if (cmd_wr) begin
                    state_d = ST_LOCKED;                           // [R3]
                end
            end
            // command writes are ignored while an erase runs
            ST_PAGE, ST_MASS: begin
                if (erase_done) begin
                    state_d = ST_LOCKED;                           // [R18]
                end
            end
            default: state_d = ST_LOCKED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // erase request to the array
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            mass_q  <= 1'b0;
            page_q  <= 8'h00;
        end else begin
            start_q <= go_page | go_mass;
            if (go_page | go_mass) begin
                mass_q <= go_mass;
                page_q <= page_select;                             // [R5]
            end
        end
    end

    // ------------------------------------------------------------
    // sector protect access and trim data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            protect_q <= 1'b0;
        end else if (cmd_wr && !busy) begin
            protect_q <= (rf_wdata == `CMD_PROTECT_ACCESS);        // [R8]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_q  <= `TRIM_RESET;
            rdata_q <= `RDATA_RESET;
        end else begin
            if (trim_wr) begin
                trim_q <= rf_wdata;                                // [R11]
            end
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // option bytes and watchdog
    // ------------------------------------------------------------
    option_if opt ();

    // option bytes are programmed like flash: only while unlocked
    assign opt_addr        = (mem_addr == `OPTION_ADDR0) |
                             (mem_addr == `OPTION_ADDR1);          // [R13]
    assign opt.wr          = mem_wr & opt_addr & prog_enable;      // [R1]
    assign opt.idx         = mem_addr[0];
    assign opt.wdata       = mem_wdata;
    assign opt.wdt_instr   = wdt_instr;
    assign opt.wdt_timeout = wdt_timeout;

    option_store u_opt (
        .clk   (clk),
        .rst_n (rst_n),
        .por_n (por_n),
        .opt   (opt)
    );

    info_decode u_dec (
        .clk         (clk),
        .rst_n       (rst_n),
        .addr        (mem_addr),
        .info_sel    (info_sel),
        .info_denied (info_denied),
        .option_sel  (option_sel)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_enable <= 1'b0;
        end else begin
            prog_enable <= (state_d == ST_UNLOCKED);               // [R1]
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rf_rdata              = rdata_q;
    assign erase_start           = start_q;
    assign erase_mass            = mass_q;
    assign erase_page            = page_q;
    assign sector_protect_access = protect_q;
    assign option_byte0          = opt.byte0;
    assign option_byte1          = opt.byte1;
    assign wdt_run               = opt.wdt_run;
    assign wdt_irq               = opt.wdt_irq;
    assign wdt_sys_reset         = opt.wdt_sys_reset;
endmodule

// [bench/flash_cmd_unit_monitor.sv]
// port-level assertions for the flash command unit
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_unit_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register file
    input wire logic [11:0] rf_addr,
    input wire logic        rf_wr,
    input wire logic        rf_rd,
    input wire logic [7:0]  rf_wdata,
    input wire logic [7:0]  rf_rdata,
    input wire logic        dbg_write,
    // flash array
    input wire logic [7:0]  page_select,
    input wire logic        erase_done,
    input wire logic        erase_start,
    input wire logic        erase_mass,
    input wire logic [7:0]  erase_page,
    input wire logic        prog_enable,
    input wire logic        sector_protect_access,
    // memory bus and watchdog
    input wire logic [15:0] mem_addr,
    input wire logic        mem_wr,
    input wire logic        info_sel,
    input wire logic        info_denied,
    input wire logic        option_sel,
    input wire logic        wdt_instr,
    input wire logic        wdt_timeout,
    input wire logic [7:0]  option_byte0,
    input wire logic [7:0]  option_byte1,
    input wire logic        wdt_run,
    input wire logic        wdt_irq,
    input wire logic        wdt_sys_reset
);
    import flash_cmd_pkg::*;
    byte_t last_q;
    byte_t prev_q;
    logic  busy_q;
    wire   cmd_wr = rf_wr && rf_addr == `FLASH_COMMAND_PORT_ADDR;
    // writes while an erase runs are dropped, so keep them out of checks
    wire   idle = !busy_q && !erase_start && !erase_done;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 8'h00;
            prev_q <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            if (cmd_wr) begin
                last_q <= rf_wdata;
                prev_q <= last_q;
            end
            busy_q <= erase_start | (busy_q & ~erase_done);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    unlock_seq_a: assert property ($rose(prog_enable) |->
        last_q == `CMD_UNLOCK_SECOND && prev_q == `CMD_UNLOCK_FIRST)
        else $error("unlock without both codes");
    page_start_a: assert property (erase_start && !erase_mass |->
        $past(cmd_wr && prog_enable && rf_wdata == `CMD_PAGE_ERASE)
        && erase_page == $past(page_select)) else $error("bad page erase");
    mass_start_a: assert property (erase_start && erase_mass |->
        $past(cmd_wr && dbg_write && prog_enable
        && rf_wdata == `CMD_MASS_ERASE)) else $error("bad mass erase");
    seq_relock_a: assert property (prog_enable && cmd_wr
        |=> !prog_enable) else $error("still unlocked after third code");
    protect_grant_a: assert property (cmd_wr && idle |=>
        sector_protect_access == ($past(rf_wdata) == `CMD_PROTECT_ACCESS))
        else $error("protect access wrong");
    read_zero_a: assert property (!(rf_rd && (rf_addr ==
        `TRIM_BIT_DATA_ADDR || rf_addr == `FLASH_STATE_PORT_ADDR))
        |=> rf_rdata == 8'h00) else $error("stray read data");
    status_read_a: assert property (rf_rd
        && rf_addr == `FLASH_STATE_PORT_ADDR |=> rf_rdata[7:6] == 2'b00
        && (!$past(prog_enable) || rf_rdata[5:0] == `STAT_UNLOCKED))
        else $error("status read wrong");
    mem_decode_a: assert property ($past(rst_n) |->
        info_sel == ($past(mem_addr) >= `INFO_AREA_LO)
        && info_denied == ($past(mem_addr) inside {[16'hfe80:16'hfeff]})
        && option_sel == ($past(mem_addr) <= `OPTION_ADDR1))
        else $error("memory decode wrong");
    option_keep_a: assert property ($past(rst_n) &&
        !$past(mem_wr && prog_enable && mem_addr <= `OPTION_ADDR1)
        |-> $stable(option_byte0) && $stable(option_byte1))
        else $error("option bytes changed");
    wdt_resp_a: assert property (wdt_run && wdt_timeout |=>
        wdt_sys_reset == $past(option_byte0[`OPT_WATCHDOG_RESPONSE_SELECT_BIT])
        && wdt_irq != $past(option_byte0[`OPT_WATCHDOG_RESPONSE_SELECT_BIT]))
        else $error("timeout response wrong");
    wdt_auto_a: assert property ($past(rst_n) && !$past(rst_n, 2)
        && !$past(option_byte0[`OPT_WATCHDOG_ALWAYS_ON_BIT]) |-> wdt_run)
        else $error("watchdog not auto started");
    wdt_start_a: assert property (wdt_instr || wdt_run |=> wdt_run)
        else $error("watchdog not running");
endmodule

bind flash_cmd_unit flash_cmd_unit_monitor mon_u (.*);

// [bench/flash_cmd_unit_tb_top.sv]
// self-checking bench for the flash command unit
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_cmd_unit_tb_top;
    import flash_cmd_pkg::*;
    logic      clk, rst_n, por_n, rf_wr, rf_rd, dbg_write, erase_done;
    logic      mem_wr, wdt_instr, wdt_timeout, erase_start, erase_mass;
    logic      prog_enable, sector_protect_access, info_sel, info_denied;
    logic      option_sel, wdt_run, wdt_irq, wdt_sys_reset;
    rf_addr_t  rf_addr, a;
    byte_t     rf_wdata, rf_rdata, page_select, erase_page, mem_wdata, b;
    byte_t     option_byte0, option_byte1;
    mem_addr_t mem_addr;
    int        failures, samples_checked;

    flash_cmd_unit dut_u (.*);

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // expectations and bus tasks
    // ------------------------------------------------------------
    function automatic byte_t sts(input logic [5:0] c);
        return {2'b00, c};
    endfunction
    function automatic byte_t dec(input mem_addr_t m);
        return {5'h00, m >= `INFO_AREA_LO, m inside {[16'hfe80:16'hfeff]},
                m <= `OPTION_ADDR1};
    endfunction
    task automatic chk(input byte_t got, input byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes stay up between back-to-back calls; nop drops them
    task automatic nop();
        {rf_wr, rf_rd, mem_wr, erase_done, wdt_instr, wdt_timeout} = 6'h00;
        @(negedge clk);
    endtask
    task automatic wr(input rf_addr_t ad, input byte_t d, input logic g);
        {rf_wr, rf_rd, dbg_write, rf_addr, rf_wdata} = {3'b100 | g, ad, d};
        @(negedge clk);
    endtask
    task automatic rd(input rf_addr_t ad, input byte_t e);
        {rf_wr, rf_rd, rf_addr} = {2'b01, ad};
        @(negedge clk);
        chk(rf_rdata, e);
    endtask
    task automatic cw(input byte_t d, input logic g = 1'b0);
        wr(`FLASH_COMMAND_PORT_ADDR, d, g);
    endtask
    task automatic st(input byte_t e);
        rd(`FLASH_STATE_PORT_ADDR, e);
    endtask
    task automatic unl();
        cw(`CMD_UNLOCK_FIRST);
        cw(`CMD_UNLOCK_SECOND);
    endtask
    task automatic mw(input mem_addr_t m, input byte_t d);
        {mem_wr, mem_addr, mem_wdata} = {1'b1, m, d};
        @(negedge clk);
    endtask
    task automatic fin_erase();
        erase_done = 1'b1;
        @(negedge clk);
        nop();
    endtask
    task automatic rst_pulse();
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(42103));
        {rst_n, por_n, dbg_write, rf_wr, rf_rd, erase_done} = 6'h00;
        {mem_wr, wdt_instr, wdt_timeout} = 3'h0;
        {rf_addr, rf_wdata, page_select} = 28'h0;
        {mem_addr, mem_wdata} = {16'h0100, 8'h00};
        repeat (3) @(negedge clk);
        {rst_n, por_n} = 2'b11;
        nop();
        st(8'h00);
        rd(`TRIM_BIT_DATA_ADDR, `TRIM_RESET);
        chk(option_byte0, `OPT_ERASED);
        chk(8'(wdt_run), 8'h00);
        cw(`CMD_PAGE_ERASE);
        chk(8'(erase_start), 8'h00);
        done("reset");
        for (int i = 0; i < 4; i++) begin
            page_select = 8'($urandom);
            cw(`CMD_UNLOCK_FIRST);
            st(sts(`STAT_FIRST));
            cw(`CMD_UNLOCK_SECOND);
            chk(8'(prog_enable), 8'h01);
            cw(`CMD_PAGE_ERASE);
            chk({5'h00, erase_start, erase_mass, prog_enable}, 8'h04);
            chk(erase_page, page_select);
            b = page_select;
            page_select = ~b;
            cw(`CMD_UNLOCK_FIRST);
            st(sts(`STAT_PAGE_ERASE));
            chk(erase_page, b);
            fin_erase();
            st(sts(`STAT_LOCKED));
        end
        done("page");
        unl();
        cw(`CMD_MASS_ERASE);
        chk(8'(erase_start), 8'h00);
        st(sts(`STAT_LOCKED));
        unl();
        cw(`CMD_MASS_ERASE, 1'b1);
        chk({6'h00, erase_start, erase_mass}, 8'h03);
        st(sts(`STAT_MASS_ERASE));
        fin_erase();
        st(sts(`STAT_LOCKED));
        done("mass");
        for (int i = 0; i < 16; i++) begin
            do b = 8'($urandom); while (b inside {8'h73, 8'h8c, 8'h95});
            cw(`CMD_UNLOCK_FIRST);
            cw(b);
            cw(`CMD_UNLOCK_SECOND);
            chk(8'(prog_enable), 8'h00);
            unl();
            cw(b);
            st(sts(`STAT_LOCKED));
        end
        done("order");
        b = 8'($urandom);
        cw(`CMD_UNLOCK_FIRST);
        wr(`TRIM_BIT_DATA_ADDR, b, 1'b0);
        cw(`CMD_UNLOCK_SECOND);
        chk(8'(prog_enable), 8'h01);
        rd(`TRIM_BIT_DATA_ADDR, b);
        st(sts(`STAT_UNLOCKED));
        cw(`CMD_PROTECT_ACCESS);
        chk({6'h00, sector_protect_access, prog_enable}, 8'h02);
        cw(8'h00);
        chk(8'(sector_protect_access), 8'h00);
        for (int i = 0; i < 8; i++) begin
            do a = 12'($urandom); while (a inside {12'hff7, 12'hff8});
            rd(a, 8'h00);
        end
        done("trim");
        for (int i = 0; i < 24; i++) begin
            mem_addr = i[0] ? {7'h7f, 9'($urandom)} : 16'($urandom);
            if (i < 8) mem_addr = 16'({16'hfe00, 16'hfdff, 16'hffff,
                16'hfe80, 16'hfeff, 16'h0000, 16'h0001, 16'h0002}
                >> (16 * (7 - i)));
            @(negedge clk);
            chk({5'h00, info_sel, info_denied, option_sel}, dec(mem_addr));
        end
        done("decode");
        mw(`OPTION_ADDR0, 8'h00);
        chk(option_byte0, `OPT_ERASED);
        nop();
        unl();
        // drop the write strobe, or 8ch is taken again and relocks
        nop();
        mw(`OPTION_ADDR0, 8'h3f);
        mw(`OPTION_ADDR1, b);
        nop();
        rst_pulse();
        chk(option_byte0, 8'h3f);
        chk(option_byte1, b);
        chk(8'(wdt_run), 8'h01);
        wdt_timeout = 1'b1;
        @(negedge clk);
        chk({6'h00, wdt_irq, wdt_sys_reset}, 8'h02);
        nop();
        unl();
        nop();
        mw(`OPTION_ADDR0, 8'hc0);
        nop();
        rst_pulse();
        chk(8'(wdt_run), 8'h00);
        wdt_timeout = 1'b1;
        @(negedge clk);
        chk({6'h00, wdt_irq, wdt_sys_reset}, 8'h00);
        nop();
        wdt_instr = 1'b1;
        @(negedge clk);
        nop();
        chk(8'(wdt_run), 8'h01);
        wdt_timeout = 1'b1;
        @(negedge clk);
        chk({6'h00, wdt_irq, wdt_sys_reset}, 8'h01);
        nop();
        done("option");
        final_report();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule
